// ===== verilog/tcc_timer.sv
// 16-bit capture/compare timer with cascaded 8-bit event counter and gate
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module tcc_timer #(
  parameter int unsigned PRESC_W = 6
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_trigger_pin_a,
  input  wire logic        i_trigger_pin_b,
  input  wire logic        i_event_input_pin,
  output logic             o_timer_output_pin,
  output logic             o_first_match_irq,
  output logic             o_second_match_irq,
  output logic             o_low_counter_irq,
  output logic             o_gating_timer_irq
);
  import tcc_pkg::*;

  // Prescaler codes 0..6 pick a divide by 2**code, so the divider needs six bits
  initial begin
    if (PRESC_W < 6) $error("PRESC_W must be at least 6");
  end

  typedef struct packed {
    logic [1:0]         mode;
    logic [2:0]         presc;
    logic               tog2;
    logic               lvr;
    logic               lvs;
    logic               tog1;
    logic               cc1_cap;
    logic               cc2_cap;
    logic               cc1_rev;
    logic [1:0]         es_a;
    logic [1:0]         es_b;
    logic               low_en;
    logic               low_rise;
    logic               gate_sel;
    logic               gt_en;
    logic               gt_lvl;
    logic [7:0]         low_cmp;
    logic [7:0]         gt_per;
    logic [7:0]         gt_duty;
    logic [7:0]         low_cnt;
    logic [7:0]         gt_cnt;
    logic [15:0]        cnt;
    logic [15:0]        cc1;
    logic [15:0]        cc2;
    logic [PRESC_W-1:0] div;
    tcc_mc_t            mc;
    tcc_gt_t            gt;
    logic               tout;
    logic               gt_out;
    logic               gate_blk;
    logic [3:0]         flags;
    logic               irq1;
    logic               irq2;
    logic               irql;
    logic               irqg;
    logic               pready;
    logic               perr;
    logic [31:0]        prdata;
  } tcc_state_t;

  tcc_state_t s_r;
  tcc_state_t s_nxt;

  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic       ctick;
  logic       m1;
  logic       m2;
  logic       a_edge;
  logic       a_rev;
  logic       b_edge;
  logic       ev_edge;
  logic       gate_src;
  logic       wr;
  logic [3:0] set_f;

  tcc_pin_sync #(
    .N (3)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_pin     ({i_event_input_pin, i_trigger_pin_b, i_trigger_pin_a}),
    .o_level   (),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  function automatic logic edge_ok(input logic [1:0] es, input logic r, input logic f);
    return ((es == ES_FALL) & f) | ((es == ES_RISE) & r) | ((es == ES_BOTH) & (r | f));
  endfunction : edge_ok

  function automatic logic [PRESC_W-1:0] presc_mask(input logic [2:0] p);
    return PRESC_W'((1 << p) - 1);
  endfunction : presc_mask

  always_comb begin
    s_nxt        = s_r;
    s_nxt.irq1   = 1'b0;
    s_nxt.irq2   = 1'b0;
    s_nxt.irql   = 1'b0;
    s_nxt.irqg   = 1'b0;
    s_nxt.pready = 1'b0;
    s_nxt.div    = s_r.div + PRESC_W'(1);

    // Trigger pin edges only count while the timer runs; event pin edges count even when stopped
    a_edge  = (s_r.mode != MODE_STOP) & edge_ok(s_r.es_a, pin_rise[0], pin_fall[0]);
    a_rev   = (s_r.mode != MODE_STOP) & edge_ok(s_r.es_a, pin_fall[0], pin_rise[0]);
    b_edge  = (s_r.mode != MODE_STOP) & edge_ok(s_r.es_b, pin_rise[1], pin_fall[1]);
    ev_edge = s_r.low_rise ? pin_rise[2] : pin_fall[2];

    // Cascade clock is the registered low counter match pulse
    if (s_r.presc == PRESC_CASCADE) begin
      ctick = s_r.irql;
    end else begin
      ctick = (s_r.div & presc_mask(s_r.presc)) == presc_mask(s_r.presc);
    end

    // Compare matches only in the running state
    m1 = (s_r.mc == MC_RUN) & ctick & ~s_r.cc1_cap & (s_r.cnt == s_r.cc1);
    m2 = (s_r.mc == MC_RUN) & ctick & ~s_r.cc2_cap & (s_r.cnt == s_r.cc2);

    // Main counter
    if (s_r.mode == MODE_STOP) begin
      s_nxt.cnt = '0;
      s_nxt.mc  = MC_STOPPED;
      if (s_r.lvs & ~s_r.lvr) begin
        s_nxt.tout = 1'b1;
      end else if (s_r.lvr & ~s_r.lvs) begin
        s_nxt.tout = 1'b0;
      end
    end else begin
      // Output simply carries on from the preset level when started
      if ((m1 & s_r.tog1) ^ (m2 & s_r.tog2)) begin
        s_nxt.tout = ~s_r.tout;
      end
      case (s_r.mc)
        MC_STOPPED: begin
          s_nxt.mc = MC_SYNC;
        end
        MC_SYNC: begin
          if (ctick) begin
            s_nxt.mc = MC_RUN;
          end
        end
        MC_RUN: begin
          // Wrapping stays in MC_RUN, so no clock is lost again
          if (m1 & (s_r.mode == MODE_MATCH)) begin
            s_nxt.cnt = '0;
          end else if (ctick) begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
          end
        end
        default: begin
          s_nxt.mc = MC_STOPPED;
        end
      endcase
      if (a_edge & (s_r.mode == MODE_EXT)) begin
        s_nxt.cnt = '0;
      end
    end
    s_nxt.irq1 = m1;
    s_nxt.irq2 = m2;

    // Captures
    if (s_r.cc2_cap & a_edge) begin
      s_nxt.cc2  = s_r.cnt;
      s_nxt.irq2 = 1'b1;
    end
    if (s_r.cc1_cap & s_r.cc1_rev & a_rev) begin
      s_nxt.cc1 = s_r.cnt;
    end else if (s_r.cc1_cap & ~s_r.cc1_rev & b_edge) begin
      s_nxt.cc1  = s_r.cnt;
      s_nxt.irq1 = 1'b1;
    end

    // Gate enable is taken at the event edge and used for the next one
    gate_src = ~s_r.gate_sel | s_r.gt_out;
    if (!s_r.low_en) begin
      s_nxt.low_cnt  = '0;
      // A stopped low counter reopens its gate latch so a restart loses no edge
      s_nxt.gate_blk = 1'b0;
    end else if (ev_edge) begin
      s_nxt.gate_blk = ~gate_src;
      if (!s_r.gate_blk) begin
        if (s_r.low_cnt == s_r.low_cmp) begin
          s_nxt.low_cnt = '0;
          s_nxt.irql    = 1'b1;
        end else begin
          s_nxt.low_cnt = s_r.low_cnt + 8'h01;
        end
      end
    end

    // Gating PWM timer
    case (s_r.gt)
      GT_IDLE: begin
        s_nxt.gt_cnt = '0;
        s_nxt.gt_out = s_r.gt_lvl;
        if (s_r.gt_en) begin
          s_nxt.gt = GT_HOLD;
        end
      end
      GT_HOLD, GT_RUN: begin
        s_nxt.gt_cnt = s_r.gt_cnt + 8'h01;
        if (s_r.gt_cnt == s_r.gt_per) begin
          s_nxt.gt_cnt = '0;
          s_nxt.gt_out = ~s_r.gt_lvl;
          s_nxt.irqg   = 1'b1;
          s_nxt.gt     = GT_RUN;
        end else if ((s_r.gt == GT_RUN) & (s_r.gt_cnt == s_r.gt_duty)) begin
          s_nxt.gt_out = s_r.gt_lvl;
        end
        if (!s_r.gt_en) begin
          s_nxt.gt = GT_IDLE;
        end
      end
      default: begin
        s_nxt.gt = GT_IDLE;
      end
    endcase

    // APB: one wait-free access phase, answer registered from the setup cycle
    wr    = i_psel & i_penable & s_r.pready & i_pwrite;
    set_f = {s_nxt.irqg, s_nxt.irql, s_nxt.irq2, s_nxt.irq1};
    s_nxt.flags = s_r.flags | set_f;
    if (i_psel & ~i_penable) begin
      s_nxt.pready = 1'b1;
      s_nxt.perr   = 1'b0;
      s_nxt.prdata = '0;
      case (i_paddr)
        ADDR_CTRL: begin
          s_nxt.prdata[CTRL_MODE_LSB +: 2]  = s_r.mode;
          s_nxt.prdata[CTRL_PRESC_LSB +: 3] = s_r.presc;
          s_nxt.prdata[CTRL_TOG2]           = s_r.tog2;
          s_nxt.prdata[CTRL_PRE_CLR]        = s_r.lvr;
          s_nxt.prdata[CTRL_PRE_SET]        = s_r.lvs;
          s_nxt.prdata[CTRL_TOG1]           = s_r.tog1;
          s_nxt.prdata[CTRL_CC1_CAP]        = s_r.cc1_cap;
          s_nxt.prdata[CTRL_CC2_CAP]        = s_r.cc2_cap;
          s_nxt.prdata[CTRL_CC1_REV]        = s_r.cc1_rev;
          s_nxt.prdata[CTRL_ES_A_LSB +: 2]  = s_r.es_a;
          s_nxt.prdata[CTRL_ES_B_LSB +: 2]  = s_r.es_b;
        end
        ADDR_COUNT:    s_nxt.prdata[15:0] = s_r.cnt;
        ADDR_CC1:      s_nxt.prdata[15:0] = s_r.cc1;
        ADDR_CC2:      s_nxt.prdata[15:0] = s_r.cc2;
        ADDR_LOW_CTRL: begin
          s_nxt.prdata[LOW_EN]       = s_r.low_en;
          s_nxt.prdata[LOW_RISE]     = s_r.low_rise;
          s_nxt.prdata[LOW_GATE_SEL] = s_r.gate_sel;
          s_nxt.prdata[LOW_GT_EN]    = s_r.gt_en;
          s_nxt.prdata[LOW_GT_LVL]   = s_r.gt_lvl;
        end
        ADDR_LOW_CMP:  s_nxt.prdata[23:0] = {s_r.gt_duty, s_r.gt_per, s_r.low_cmp};
        ADDR_LOW_CNT:  s_nxt.prdata[7:0]  = s_r.low_cnt;
        ADDR_STATUS:   s_nxt.prdata[4:0]  = {s_r.tout, s_r.flags};
        default:       s_nxt.perr = 1'b1;
      endcase
    end
    if (wr) begin
      case (i_paddr)
        ADDR_CTRL: begin
          s_nxt.mode    = i_pwdata[CTRL_MODE_LSB +: 2];
          s_nxt.presc   = i_pwdata[CTRL_PRESC_LSB +: 3];
          s_nxt.tog2    = i_pwdata[CTRL_TOG2];
          s_nxt.lvr     = i_pwdata[CTRL_PRE_CLR];
          s_nxt.lvs     = i_pwdata[CTRL_PRE_SET];
          s_nxt.tog1    = i_pwdata[CTRL_TOG1];
          s_nxt.cc1_cap = i_pwdata[CTRL_CC1_CAP];
          s_nxt.cc2_cap = i_pwdata[CTRL_CC2_CAP];
          s_nxt.cc1_rev = i_pwdata[CTRL_CC1_REV];
          s_nxt.es_a    = i_pwdata[CTRL_ES_A_LSB +: 2];
          s_nxt.es_b    = i_pwdata[CTRL_ES_B_LSB +: 2];
        end
        ADDR_CC1:      s_nxt.cc1 = i_pwdata[15:0];
        ADDR_CC2:      s_nxt.cc2 = i_pwdata[15:0];
        ADDR_LOW_CTRL: begin
          s_nxt.low_en   = i_pwdata[LOW_EN];
          s_nxt.low_rise = i_pwdata[LOW_RISE];
          s_nxt.gate_sel = i_pwdata[LOW_GATE_SEL];
          s_nxt.gt_en    = i_pwdata[LOW_GT_EN];
          s_nxt.gt_lvl   = i_pwdata[LOW_GT_LVL];
        end
        ADDR_LOW_CMP: begin
          s_nxt.low_cmp = i_pwdata[CMP_LOW_LSB +: 8];
          s_nxt.gt_per  = i_pwdata[CMP_PER_LSB +: 8];
          s_nxt.gt_duty = i_pwdata[CMP_DUTY_LSB +: 8];
        end
        // A new event in the same cycle survives the clear
        ADDR_STATUS:   s_nxt.flags = (s_r.flags & ~i_pwdata[3:0]) | set_f;
        default:       s_nxt.flags = s_r.flags | set_f;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_prdata           = s_r.prdata;
  assign o_pready           = s_r.pready;
  assign o_pslverr          = s_r.perr;
  assign o_timer_output_pin = s_r.tout;
  assign o_first_match_irq  = s_r.irq1;
  assign o_second_match_irq = s_r.irq2;
  assign o_low_counter_irq  = s_r.irql;
  assign o_gating_timer_irq = s_r.irqg;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  a_stop_clears_count: assert property (
    s_r.mode == MODE_STOP |=> s_r.cnt == 16'h0000 && s_r.mc == MC_STOPPED)
    else $error("count not cleared while stopped");

  a_apb_ready_next: assert property (
    i_psel && !i_penable |=> o_pready ##1 !o_pready)
    else $error("pready not a single pulse after setup");

  a_cap2_on_pin_a: assert property (
    s_r.cc2_cap && a_edge && !wr |=> s_r.cc2 == $past(s_r.cnt) && o_second_match_irq)
    else $error("second capture missed pin A edge");

  a_rev_no_irq: assert property (
    s_r.cc1_cap && s_r.cc1_rev |=> !o_first_match_irq)
    else $error("first interrupt on reverse-phase capture");

  a_match_clears: assert property (
    m1 && s_r.mode == MODE_MATCH && !a_edge && !wr |=> s_r.cnt == 16'h0000 && o_first_match_irq)
    else $error("match in mode 11 did not clear and interrupt");

  a_cascade_step: assert property (
    s_r.irql && s_r.presc == PRESC_CASCADE && s_r.mc == MC_RUN
    && (s_r.mode == MODE_FREE || s_r.mode == MODE_MATCH)
    && !m1 && !wr |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
    else $error("cascade pulse did not advance main count");

  a_low_wrap: assert property (
    s_r.low_en && ev_edge && !s_r.gate_blk && s_r.low_cnt == s_r.low_cmp && !wr
    |=> s_r.low_cnt == 8'h00 && o_low_counter_irq)
    else $error("low counter match did not clear and pulse");

  a_sync_swallow: assert property (
    s_r.mc == MC_SYNC && ctick && s_r.mode != MODE_STOP && !wr && !a_edge
    |=> s_r.cnt == $past(s_r.cnt) && s_r.mc == MC_RUN)
    else $error("first count clock was not swallowed");

  a_preset_high: assert property (
    s_r.mode == MODE_STOP && s_r.lvs && !s_r.lvr |=> o_timer_output_pin)
    else $error("preset 10 did not drive output high");

  a_toggle_on_m1: assert property (
    s_r.mode != MODE_STOP && m1 && s_r.tog1 && !(m2 && s_r.tog2)
    |=> o_timer_output_pin != $past(o_timer_output_pin) && o_first_match_irq)
    else $error("output not inverted on first match");

  a_gate_hold: assert property (
    s_r.gt == GT_HOLD |-> s_r.gt_out == s_r.gt_lvl)
    else $error("gate output left default before period match");

  a_gate_resample: assert property (
    s_r.low_en && ev_edge |=> s_r.gate_blk == !$past(gate_src))
    else $error("gate enable not resampled at event edge");

  c_cascade_tick: cover property (s_r.irql && s_r.presc == PRESC_CASCADE && s_r.mc == MC_RUN);
  c_capture_b:    cover property (s_r.cc1_cap && b_edge);
  c_clear_match:  cover property (m1 && s_r.mode == MODE_MATCH);
  c_gate_run:     cover property (s_r.gt == GT_HOLD ##1 s_r.gt == GT_RUN);

endmodule : tcc_timer

// ===== common/tcc_pkg.sv
// Package for the 16-bit capture/compare timer slice with 24-bit cascade
package tcc_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_COUNT    = 8'h04;
  localparam logic [7:0] ADDR_CC1      = 8'h08;
  localparam logic [7:0] ADDR_CC2      = 8'h0C;
  localparam logic [7:0] ADDR_LOW_CTRL = 8'h10;
  localparam logic [7:0] ADDR_LOW_CMP  = 8'h14;
  localparam logic [7:0] ADDR_LOW_CNT  = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1C;

  // CTRL field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_PRESC_LSB = 2;
  localparam int CTRL_TOG2      = 5;
  localparam int CTRL_PRE_CLR   = 6;
  localparam int CTRL_PRE_SET   = 7;
  localparam int CTRL_TOG1      = 8;
  localparam int CTRL_CC1_CAP   = 9;
  localparam int CTRL_CC2_CAP   = 10;
  localparam int CTRL_CC1_REV   = 11;
  localparam int CTRL_ES_A_LSB  = 12;
  localparam int CTRL_ES_B_LSB  = 14;

  // LOW_CTRL field positions
  localparam int LOW_EN       = 0;
  localparam int LOW_RISE     = 1;
  localparam int LOW_GATE_SEL = 2;
  localparam int LOW_GT_EN    = 3;
  localparam int LOW_GT_LVL   = 4;

  // LOW_CMP field positions
  localparam int CMP_LOW_LSB  = 0;
  localparam int CMP_PER_LSB  = 8;
  localparam int CMP_DUTY_LSB = 16;

  // STATUS positions: flags 0..3 write one to clear, bit 4 the output level
  localparam int FLG_M1  = 0;
  localparam int FLG_M2  = 1;
  localparam int FLG_LOW = 2;
  localparam int FLG_GT  = 3;
  localparam int STS_OUT = 4;

  localparam logic [1:0] MODE_STOP  = 2'b00;
  localparam logic [1:0] MODE_FREE  = 2'b01;
  localparam logic [1:0] MODE_EXT   = 2'b10;
  localparam logic [1:0] MODE_MATCH = 2'b11;

  localparam logic [2:0] PRESC_CASCADE = 3'h7;

  localparam logic [1:0] ES_FALL = 2'b00;
  localparam logic [1:0] ES_RISE = 2'b01;
  localparam logic [1:0] ES_BOTH = 2'b11;

  typedef enum logic [1:0] {MC_STOPPED, MC_SYNC, MC_RUN} tcc_mc_t;
  typedef enum logic [1:0] {GT_IDLE, GT_HOLD, GT_RUN} tcc_gt_t;

endpackage : tcc_pkg

// ===== verilog/tcc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
module tcc_pin_sync #(
  parameter int unsigned N = 3
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rstn,
  input  wire logic [N-1:0] i_pin,
  output logic      [N-1:0] o_level,
  output logic      [N-1:0] o_rise,
  output logic      [N-1:0] o_fall
);
  import tcc_pkg::*;

  initial begin
    if (N < 1) $error("tcc_pin_sync needs at least one pin");
  end

  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
    logic       rise;
    logic       fall;
  } tcc_sync_t;

  for (genvar g = 0; g < N; g++) begin : g_pin
    tcc_sync_t s_r;
    tcc_sync_t s_nxt;

    always_comb begin
      s_nxt       = s_r;
      s_nxt.sh    = {s_r.sh[1:0], i_pin[g]};
      s_nxt.rise  = 1'b0;
      s_nxt.fall  = 1'b0;
      // A change counts only once stages two and three agree
      if (s_r.sh[1] == s_r.sh[2]) begin
        s_nxt.lvl  = s_r.sh[2];
        s_nxt.rise = s_r.sh[2] & ~s_r.lvl;
        s_nxt.fall = ~s_r.sh[2] & s_r.lvl;
      end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        s_r <= '0;
      end else begin
        s_r <= s_nxt;
      end
    end

    assign o_level[g] = s_r.lvl;
    assign o_rise[g]  = s_r.rise;
    assign o_fall[g]  = s_r.fall;
  end

endmodule : tcc_pin_sync

// ===== bench/tcc_pin_model.sv
// Model of the external trigger and event pins that feed the timer slice
`timescale 1ns/1ns
module tcc_pin_model (
  input  wire logic       i_ref_clk,
  output logic      [2:0] o_pins
);
  initial begin
    o_pins = 3'b000;
  end
  // Index 0 is trigger pin A, 1 trigger pin B, 2 the event pin
  // Each level is held four clocks so the agreement filter always accepts it
  task automatic level(input int idx, input logic val);
    o_pins[idx] <= val;
    repeat (4) @(posedge i_ref_clk);
  endtask : level
  task automatic pulse(input int idx);
    level(idx, 1'b1);
    level(idx, 1'b0);
  endtask : pulse
endmodule : tcc_pin_model

// ===== bench/tb_top.sv
// Self-checking testbench for the capture, cascade and output preset timer
`timescale 1ns/1ns
module tb_top;
  import tcc_pkg::*;
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
  logic        clk, rstn, psel, pen, pwr, lerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, top, irq1, irq2, irql, irqg;
  logic [2:0]  pins;
  int          err_count, n_checks;

  tcc_timer dut (.i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_trigger_pin_a(pins[0]),
    .i_trigger_pin_b(pins[1]), .i_event_input_pin(pins[2]), .o_timer_output_pin(top),
    .o_first_match_irq(irq1), .o_second_match_irq(irq2), .o_low_counter_irq(irql),
    .o_gating_timer_irq(irqg));
  tcc_pin_model pm (.i_ref_clk(clk), .o_pins(pins));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Always entered just after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      give_verdict();
    end
    q = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : w
  task automatic r(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0000_0000, q);
  endtask : r
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  // Waits for the first (sel 0) or second (sel 1) match pulse
  task automatic wait_irq(input logic sel, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel ? irq2 : irq1) !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      err_count++;
      give_verdict();
    end
  endtask : wait_irq
  // Count expected in clear-on-match mode after a number of effective ticks
  function automatic logic [31:0] exp_cnt(input int ticks, input int top_v);
    return 32'(ticks % (top_v + 1));
  endfunction : exp_cnt

  initial begin
    logic [31:0] q, c0, c1;
    int          v, e, n;
    {psel, pen, pwr, paddr, pwdata, rstn, lerr} = '0;
    err_count = 0;
    n_checks = 0;
    void'($urandom(32));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    r(ADDR_COUNT, q); `CHK(q, 32'h0000_0000)
    r(8'h20, q); `CHK({lerr, q}, 33'h1_0000_0000)
    // Output preset while stopped: set, keep, clear
    w(ADDR_CTRL, 32'h0000_0080); idle(2); `CHK(top, 1'b1)
    w(ADDR_CTRL, 32'h0000_0000); idle(2); `CHK(top, 1'b1)
    w(ADDR_CTRL, 32'h0000_0040); idle(2); `CHK(top, 1'b0)
    // Start from a high preset, toggle on each clear-on-match interrupt
    w(ADDR_CTRL, 32'h0000_0080);
    w(ADDR_CTRL, 32'h0000_0000);
    v = 3 + ($urandom % 20);
    w(ADDR_CC1, 32'(v));
    w(ADDR_CTRL, 32'h0000_0103); idle(1); `CHK(top, 1'b1)
    wait_irq(1'b0, n); `CHK(top, 1'b0)
    wait_irq(1'b0, n); `CHK(n, v + 1)
    idle(2); `CHK(top, 1'b1)
    r(ADDR_COUNT, c0);
    r(ADDR_COUNT, c1); `CHK(c1 != c0, 1'b1)
    w(ADDR_CTRL, 32'h0000_0000);
    r(ADDR_COUNT, q); `CHK(q, 32'h0000_0000)
    // Second compare toggles the output; its rewrite runs with the toggle held off
    v = 16 + ($urandom % 64);
    w(ADDR_CC2, 32'(v));
    w(ADDR_CTRL, 32'h0000_0040);
    w(ADDR_CTRL, 32'h0000_0021);
    wait_irq(1'b1, n); `CHK(top, 1'b1)
    w(ADDR_CTRL, 32'h0000_0001);
    w(ADDR_CC2, 32'(v + 40)); idle(1);
    w(ADDR_CTRL, 32'h0000_0021);
    w(ADDR_STATUS, 32'h0000_0002); `CHK(top, 1'b1)
    wait_irq(1'b1, n); `CHK(top, 1'b0)
    w(ADDR_CTRL, 32'h0000_0000);
    // Captures: pin B into first register, pin A into second
    w(ADDR_STATUS, 32'h0000_000F);
    w(ADDR_CTRL, 32'h0000_5601);
    r(ADDR_COUNT, c0); pm.pulse(1); r(ADDR_STATUS, q); `CHK(q[1:0], 2'b01)
    r(ADDR_CC1, q); r(ADDR_COUNT, c1); `CHK(q > c0 && q < c1, 1'b1)
    r(ADDR_COUNT, c0); pm.pulse(0); r(ADDR_STATUS, q); `CHK(q[1:0], 2'b11)
    r(ADDR_CC2, q); r(ADDR_COUNT, c1); `CHK(q > c0 && q < c1, 1'b1)
    // Reverse phase of pin A into the first register raises no interrupt
    w(ADDR_CTRL, 32'h0000_0000);
    w(ADDR_CTRL, 32'h0000_5E01);
    idle($urandom % 50);
    w(ADDR_STATUS, 32'h0000_000F);
    r(ADDR_CC1, c0); pm.pulse(0); idle(4);
    r(ADDR_CC1, q); `CHK(q != c0, 1'b1)
    r(ADDR_STATUS, q); `CHK(q[1:0], 2'b10)
    w(ADDR_CTRL, 32'h0000_0000);
    // Mode 10: a valid pin A edge clears the running count three cycles before the read
    w(ADDR_CTRL, 32'h0000_1002);
    idle($urandom % 50);
    pm.pulse(0); r(ADDR_COUNT, q); `CHK(q, 32'h0000_0003)
    w(ADDR_CTRL, 32'h0000_0000);
    // Low compare kept away from the small counts used below
    w(ADDR_LOW_CMP, 32'h00B0_C0FF);
    // Event edge select: falling then rising counts, checked at each level
    for (int s = 0; s < 2; s++) begin
      w(ADDR_LOW_CTRL, 32'(1 + 2 * s));
      r(ADDR_LOW_CNT, c0);
      pm.level(2, 1'b1); idle(2); r(ADDR_LOW_CNT, q); `CHK(q, c0 + 32'(s))
      pm.level(2, 1'b0); idle(2); r(ADDR_LOW_CNT, q); `CHK(q, c0 + 1)
      w(ADDR_LOW_CTRL, 32'h0000_0000);
    end
    // Gate closed by a low default level: only the resampling edge still counts
    w(ADDR_LOW_CTRL, 32'h0000_0007);
    repeat (3) pm.pulse(2); r(ADDR_LOW_CNT, q); `CHK(q, 32'h0000_0001)
    w(ADDR_LOW_CTRL, 32'h0000_0017);
    repeat (3) pm.pulse(2); r(ADDR_LOW_CNT, q); `CHK(q, 32'h0000_0003)
    // Gating timer on, default high: open until its first period match
    w(ADDR_LOW_CTRL, 32'h0000_001F);
    repeat (4) pm.pulse(2); r(ADDR_LOW_CNT, q); `CHK(q, 32'h0000_0007)
    idle(170);
    repeat (4) pm.pulse(2); r(ADDR_LOW_CNT, q); `CHK(q, 32'h0000_0008)
    w(ADDR_LOW_CTRL, 32'h0000_0000);
    // 24-bit cascade: low compare all ones, main first, then low counter
    w(ADDR_LOW_CMP, 32'h0000_00FF);
    w(ADDR_CC1, 32'h0000_0002);
    w(ADDR_CC2, 32'h0000_0001);
    w(ADDR_CTRL, 32'h0000_001F);
    w(ADDR_LOW_CTRL, 32'h0000_0003);
    w(ADDR_STATUS, 32'h0000_000F);
    e = $urandom % 200;
    repeat (5 * 256 + e) pm.pulse(2);
    // First low match is swallowed, wrap through zero loses nothing
    r(ADDR_COUNT, c1); `CHK(c1, exp_cnt(4, 2))
    r(ADDR_LOW_CNT, q); `CHK(q, 32'(e))
    r(ADDR_STATUS, q); `CHK(q[2:0], 3'b111)
    // Software view: five low matches once the set low flag adds its one
    `CHK(exp_cnt(c1 + q[2], 2), exp_cnt(5, 2))
    repeat (2 * 256) pm.pulse(2);
    r(ADDR_COUNT, q); `CHK(q, exp_cnt(6, 2))
    give_verdict();
  end
endmodule : tb_top
